// ===== hw/mapper_pkg.sv
// Purpose: shared constants for the paged memory mapper
// Assumes: single 25 MHz clock, synchronous active-high reset
// Notes: map outputs are 12 bits, incoming address is 16 bits
//
// Functional notes
// [RQ1] sixteen twelve-bit map registers, held until rewritten
// [RQ2] address top four bits pick one register
// [RQ3] output is register above four low bits
// [RQ4] mapped outputs selectable transparent or latched
// [RQ5] pass mode: select bits on top, rest low
// [RQ6] host reloads registers to reach more pages
// [RQ7] host writes index plus data with strobe
package mapper_pkg;
  localparam int unsigned MAP_COUNT  = 16;  // number of map registers
  localparam int unsigned MAP_WIDTH  = 12;  // bits per map register
  localparam int unsigned SEL_WIDTH  = 4;   // register index width
  localparam int unsigned LOW_WIDTH  = 4;   // untouched low address bits
  localparam int unsigned ADDR_WIDTH = SEL_WIDTH + LOW_WIDTH + 8; // cpu address
  localparam int unsigned XADDR_WIDTH = MAP_WIDTH + LOW_WIDTH;    // expanded
  localparam int unsigned SEL_POS    = ADDR_WIDTH - SEL_WIDTH;    // select field
  localparam logic [MAP_WIDTH-1:0] MAP_RESET = 12'h000; // value after reset
endpackage : mapper_pkg

// ===== hw/map_write_if.sv
// Purpose: carries one map register write between mapper modules
// Assumes: same clock as the mapper core
// Notes: one-cycle write pulse with index and data
interface map_write_if;
  import mapper_pkg::*;
  logic                 wr_pulse; // one-cycle write
  logic [SEL_WIDTH-1:0] wr_index; // target register
  logic [MAP_WIDTH-1:0] wr_data;  // value to store
  modport source (output wr_pulse, output wr_index, output wr_data);
  modport sink   (input  wr_pulse, input  wr_index, input  wr_data);
endinterface : map_write_if

// ===== hw/map_write_port.sv
// Purpose: synchronises host write pins and emits one write per strobe
// Assumes: host holds index and data steady while the strobe is active
// Notes: write lands when the strobe completes (pins rise)
module map_write_port (
  input  wire logic                             sys_clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             cs_n_in,
  input  wire logic                             wr_n_in,
  input  wire logic [mapper_pkg::SEL_WIDTH-1:0] index_in,
  input  wire logic [mapper_pkg::MAP_WIDTH-1:0] data_in,
  map_write_if.source                           wr
);
  import mapper_pkg::*;

  localparam int unsigned BUS_W = 2 + SEL_WIDTH + MAP_WIDTH;

  // two-flop synchroniser on every host pin
  logic [BUS_W-1:0] meta_r, sync_r, meta_nxt, sync_nxt;
  logic             act_r, act_nxt;   // strobe seen active last cycle
  logic             pulse_r, pulse_nxt;
  logic [SEL_WIDTH-1:0] idx_r, idx_nxt;
  logic [MAP_WIDTH-1:0] dat_r, dat_nxt;
  logic             act_now;

  // strobe is chip select and write both low
  always_comb begin
    meta_nxt  = {cs_n_in, wr_n_in, index_in, data_in};
    sync_nxt  = meta_r;
    act_now   = ~sync_r[BUS_W-1] & ~sync_r[BUS_W-2];
    act_nxt   = act_now;
    // capture while active so data is from the strobe window
    idx_nxt   = act_now ? sync_r[MAP_WIDTH +: SEL_WIDTH] : idx_r;
    dat_nxt   = act_now ? sync_r[MAP_WIDTH-1:0] : dat_r;
    pulse_nxt = act_r & ~act_now; // end of strobe [RQ7]
  end

  // registers only
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_r  <= '1;
      sync_r  <= '1;
      act_r   <= 1'b0;
      pulse_r <= 1'b0;
      idx_r   <= '0;
      dat_r   <= '0;
    end else begin
      meta_r  <= meta_nxt;
      sync_r  <= sync_nxt;
      act_r   <= act_nxt;
      pulse_r <= pulse_nxt;
      idx_r   <= idx_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign wr.wr_pulse = pulse_r;
  assign wr.wr_index = idx_r;
  assign wr.wr_data  = dat_r;

  property p_pulse_after_strobe;
    @(posedge sys_clk_in) disable iff (rst_in)
      pulse_r |-> $past(act_r) && !$past(act_now);
  endproperty
  a_pulse_after_strobe: assert property (p_pulse_after_strobe) // [RQ7]
    else $error("write pulse without strobe end");

  property p_pulse_single;
    @(posedge sys_clk_in) disable iff (rst_in) pulse_r |=> !pulse_r;
  endproperty
  a_pulse_single: assert property (p_pulse_single) // [RQ7]
    else $error("write pulse longer than one cycle");
endmodule : map_write_port

// ===== hw/paged_memory_mapper.sv
// Purpose: paged address mapper turning a 16-bit cpu address into a 16-bit expanded one
// Assumes: address and mode pins come from outside and are synchronised
// Notes: outputs lag the address pins by three clocks; map writes land
//        four clocks after the host strobe ends
module paged_memory_mapper #(
  parameter int unsigned MAP_REGS = mapper_pkg::MAP_COUNT // page registers
) (
  input  wire logic                              sys_clk_in,  // 25 mhz clock
  input  wire logic                              rst_in,      // sync reset
  input  wire logic                              cs_n_in,     // write select
  input  wire logic                              wr_n_in,     // write strobe
  input  wire logic [mapper_pkg::SEL_WIDTH-1:0]  index_in,    // index, select
  input  wire logic [mapper_pkg::MAP_WIDTH-1:0]  data_in,     // map data
  input  wire logic [mapper_pkg::ADDR_WIDTH-1:0] addr_in,     // cpu address
  input  wire logic                              map_en_in,   // 1 map, 0 pass
  input  wire logic                              latch_en_in, // 1 latched
  input  wire logic                              hold_n_in,   // low freezes when latched
  output logic      [mapper_pkg::XADDR_WIDTH-1:0] xaddr_out   // expanded
);
  import mapper_pkg::*;

  // the index field can only reach a power-of-two register count
  if (MAP_REGS != (1 << SEL_WIDTH)) begin : g_bad_regs
    $error("map register count must equal two to the index width");
  end

  ////////////////////////////////////////////////////////////////////////
  // write path
  // host pins are synchronised inside the port, so a strobe shorter
  // than one clock can be missed entirely
  map_write_if wbus ();

  map_write_port u_wport (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .cs_n_in    (cs_n_in),
    .wr_n_in    (wr_n_in),
    .index_in   (index_in),
    .data_in    (data_in),
    .wr         (wbus.source)
  );

  ////////////////////////////////////////////////////////////////////////
  // map register file
  // loads come only from the write port's one-clock pulse, so a host
  // strobe can never leave an entry half written
  logic [MAP_WIDTH-1:0] map_r   [MAP_REGS]; // page registers
  logic [MAP_WIDTH-1:0] map_nxt [MAP_REGS]; // next page values

  // one generate entry per register; holds unless addressed [RQ1]
  for (genvar g = 0; g < MAP_REGS; g++) begin : g_map
    always_comb begin
      map_nxt[g] = map_r[g];
      if (wbus.wr_pulse && wbus.wr_index == SEL_WIDTH'(g)) begin
        map_nxt[g] = wbus.wr_data; // [RQ1] [RQ6]
      end
    end
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        map_r[g] <= MAP_RESET;
      end else begin
        map_r[g] <= map_nxt[g];
      end
    end
    // an entry not named by the pulse keeps its value
    property p_entry_hold;
      @(posedge sys_clk_in) disable iff (rst_in)
        !(wbus.wr_pulse && wbus.wr_index == SEL_WIDTH'(g)) |=>
          $stable(map_r[g]);
    endproperty
    a_entry_hold: assert property (p_entry_hold) // [RQ1]
      else $error("map register changed without its write");
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers for address and mode pins
  // mode pins share the same two stages, so a mode change and an
  // address change reach the output on the same clock
  localparam int unsigned IN_W = ADDR_WIDTH + SEL_WIDTH + 3;
  logic [IN_W-1:0] in_meta_r, in_sync_r, in_meta_nxt, in_sync_nxt;
  logic [ADDR_WIDTH-1:0] addr_s;   // synchronised address
  logic [SEL_WIDTH-1:0]  sel_s;    // synchronised select pins
  logic                  map_s;    // synchronised mode
  logic                  latch_s;  // synchronised latch mode
  logic                  hold_n_s; // synchronised hold

  // first stage read only by the second
  always_comb begin
    in_meta_nxt = {addr_in, index_in, map_en_in, latch_en_in, hold_n_in};
    in_sync_nxt = in_meta_r;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      in_meta_r <= in_meta_nxt;
      in_sync_r <= in_sync_nxt;
    end
  end

  assign {addr_s, sel_s, map_s, latch_s, hold_n_s} = in_sync_r;

  ////////////////////////////////////////////////////////////////////////
  // output stage
  // one flop for every mode keeps the output glitch free; the price is
  // one more clock of lag in transparent mode
  logic [SEL_WIDTH-1:0]   page_sel;  // chosen register
  logic [XADDR_WIDTH-1:0] mapped;    // map mode value
  logic [XADDR_WIDTH-1:0] passed;    // pass mode value
  logic [XADDR_WIDTH-1:0] xaddr_r, xaddr_nxt;

  // transparent mode still costs one register so outputs are flopped
  always_comb begin
    page_sel  = addr_s[SEL_POS +: SEL_WIDTH];              // [RQ2]
    mapped    = {map_r[page_sel], addr_s[LOW_WIDTH-1:0]};  // [RQ3]
    passed    = {sel_s, {(XADDR_WIDTH-SEL_WIDTH){1'b0}}};  // [RQ5]
    xaddr_nxt = xaddr_r;
    if (!map_s) begin
      xaddr_nxt = passed;                                  // [RQ5]
    end else if (!latch_s || hold_n_s) begin
      xaddr_nxt = mapped;                                  // [RQ4]
    end
    // latched and hold low: keep last output value [RQ4]
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      xaddr_r <= '0;
    end else begin
      xaddr_r <= xaddr_nxt;
    end
  end

  assign xaddr_out = xaddr_r;

  ////////////////////////////////////////////////////////////////////////
  // checks; they watch the synchronised pins, one clock ahead of the
  // output flop, so every consequent but that of p_index looks one clock later
  // entry taken as it stood at the sampling edge: a write landing on
  // that same edge must not count yet
  property p_map_value;
    @(posedge sys_clk_in) disable iff (rst_in)
      map_s && (!latch_s || hold_n_s) |=>
        xaddr_r == {$past(map_r[addr_s[ADDR_WIDTH-1 -: SEL_WIDTH]]),
                    $past(addr_s[LOW_WIDTH-1:0])};
  endproperty
  a_map_value: assert property (p_map_value) // [RQ3]
    else $error("mapped output mismatch");

  property p_index;
    @(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |-> page_sel == addr_s[ADDR_WIDTH-1 -: SEL_WIDTH];
  endproperty
  a_index: assert property (p_index) // [RQ2]
    else $error("wrong register index");

  property p_pass;
    @(posedge sys_clk_in) disable iff (rst_in)
      !map_s |=> xaddr_r == {$past(sel_s), 12'h000};
  endproperty
  a_pass: assert property (p_pass) // [RQ5]
    else $error("pass mode output wrong");

  sequence s_latched_hold;
    map_s && latch_s && !hold_n_s;
  endsequence
  property p_latch;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_latched_hold |=> $stable(xaddr_r);
  endproperty
  a_latch: assert property (p_latch) // [RQ4]
    else $error("latched output changed");

  property p_write;
    @(posedge sys_clk_in) disable iff (rst_in)
      wbus.wr_pulse |=> map_r[$past(wbus.wr_index)] == $past(wbus.wr_data);
  endproperty
  a_write: assert property (p_write) // [RQ1]
    else $error("map register not written");

  property p_hold_reg;
    @(posedge sys_clk_in) disable iff (rst_in)
      !wbus.wr_pulse |=> map_r[0] == $past(map_r[0]);
  endproperty
  a_hold_reg: assert property (p_hold_reg) // [RQ1]
    else $error("map register changed without write");

  // low address bits pass through untouched in every mapped cycle not frozen by a latched hold
  property p_low_bits;
    @(posedge sys_clk_in) disable iff (rst_in)
      map_s && (!latch_s || hold_n_s) |=>
        xaddr_r[LOW_WIDTH-1:0] == $past(addr_s[LOW_WIDTH-1:0]);
  endproperty
  a_low_bits: assert property (p_low_bits) // [RQ3]
    else $error("low address bits altered");

  // latched with hold high follows the address like transparent mode
  sequence s_latched_follow;
    map_s && latch_s && hold_n_s;
  endsequence
  property p_latch_follow;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_latched_follow |=>
        xaddr_r[LOW_WIDTH-1:0] == $past(addr_s[LOW_WIDTH-1:0]);
  endproperty
  a_latch_follow: assert property (p_latch_follow) // [RQ4]
    else $error("latched output did not follow with hold high");

  // two quiet clocks: pins settled through the pipe, no map load landed
  sequence s_quiet;
    $stable(in_sync_r) && !wbus.wr_pulse;
  endsequence
  sequence s_quiet_twice;
    s_quiet ##1 s_quiet;
  endsequence
  property p_output_stands;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_quiet_twice |=> $stable(xaddr_r);
  endproperty
  a_output_stands: assert property (p_output_stands) // [RQ4]
    else $error("expanded address moved with quiet inputs");
endmodule : paged_memory_mapper

// ===== sim/host_model.sv
// Purpose: host processor model driving map writes and cpu addresses
// Assumes: pins change 1 ns after the rising clock edge
// Notes: data pins show inverted junk once a write is over
module host_model
  import mapper_pkg::*;
(
  input  wire logic                  sys_clk_in,
  output logic                       cs_n_out,
  output logic                       wr_n_out,
  output logic [SEL_WIDTH-1:0]       index_out,
  output logic [MAP_WIDTH-1:0]       data_out,
  output logic [ADDR_WIDTH-1:0]      addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////
  // idle pins at time zero, strobe inactive
  initial begin
    {cs_n_out, wr_n_out} = 2'h3;
    index_out = 4'h0;
    data_out = 12'h000;
    addr_out = 16'h0000;
  end
  // one write; sel low keeps chip select high so it must be ignored
  task automatic write_map(input logic [3:0] idx, input logic [11:0] val,
                           input logic sel);
    @(posedge sys_clk_in) #1;
    cs_n_out = ~sel;
    wr_n_out = 1'b0;
    index_out = idx;
    data_out = val;
    repeat (4) @(posedge sys_clk_in); // low four cycles, min one
    #1 {cs_n_out, wr_n_out} = 2'h3;
    repeat (3) @(posedge sys_clk_in); // hold data past the sync lag
    #1 data_out = ~val; // released: no stale value left
    repeat (6) @(posedge sys_clk_in); // commit and high time
  endtask
  // new cpu address; look uses it to pick a page through the map
  task automatic set_addr(input logic [15:0] a);
    @(posedge sys_clk_in) #1 addr_out = a;
  endtask
  // pass-mode select pins share the index lines
  task automatic set_sel(input logic [3:0] s);
    @(posedge sys_clk_in) #1 index_out = s;
  endtask
endmodule // host_model

// ===== sim/tb_paged_memory_mapper.sv
// Purpose: self-checking bench for the paged memory mapper
// Assumes: outputs lag address and mode pins by three clocks
// Notes: expected map contents kept in a local shadow array
module tb_paged_memory_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  import mapper_pkg::*;
  logic                    sys_clk_in = 1'b0;  // 25 MHz
  logic                    rst_in     = 1'b1;  // sync, active high
  logic                    cs_n, wr_n;         // host strobe pins
  logic [SEL_WIDTH-1:0]    index;              // index / select pins
  logic [MAP_WIDTH-1:0]    data;               // map data pins
  logic [ADDR_WIDTH-1:0]   addr;               // cpu address
  logic                    map_en = 1'b1;      // mode pins
  logic                    latch_en = 1'b0;
  logic                    hold_n = 1'b1;
  logic [XADDR_WIDTH-1:0]  xaddr;              // expanded address
  logic [MAP_WIDTH-1:0]    shadow [16];        // expected registers
  int                      n_mismatch = 0;
  int                      comparisons = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////
  host_model host (.sys_clk_in(sys_clk_in), .cs_n_out(cs_n),
    .wr_n_out(wr_n), .index_out(index), .data_out(data), .addr_out(addr));
  paged_memory_mapper dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .cs_n_in(cs_n), .wr_n_in(wr_n), .index_in(index), .data_in(data),
    .addr_in(addr), .map_en_in(map_en), .latch_en_in(latch_en),
    .hold_n_in(hold_n), .xaddr_out(xaddr));
  ////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // set address, let the three-stage pipe fill, compare
  task automatic look(logic [15:0] a, logic [15:0] exp);
    host.set_addr(a);
    repeat (4) @(posedge sys_clk_in);
    #1 check("xaddr", xaddr, exp);
  endtask
  task automatic put(logic [3:0] i, logic [11:0] v);
    host.write_map(i, v, 1'b1);
    shadow[i] = v;
  endtask
  ////////////////////////////////////////////////////////////////////
  // every register written, then each picked by the top bits
  task automatic t_map_all();
    for (int i = 0; i < 16; i++) put(4'(i), 12'ha50 ^ 12'(i * 273));
    for (int i = 0; i < 16; i++) begin
      look({4'(i), 8'h96, 4'(15 - i)}, {shadow[i], 4'(15 - i)});
    end
  endtask
  // strobe without chip select, then a reload of the same register
  task automatic t_refuse_reload();
    host.write_map(4'h5, 12'hfff, 1'b0);
    look(16'h5003, {shadow[5], 4'h3});
    put(4'h5, 12'h123);
    look(16'h5ffe, {12'h123, 4'he});
  endtask
  // pass mode: select pins on top, rest low with the address held at ffff
  task automatic t_pass();
    host.set_addr(16'hffff);
    @(posedge sys_clk_in) #1 map_en = 1'b0;
    for (int i = 0; i < 16; i++) begin
      host.set_sel(4'(i));
      repeat (4) @(posedge sys_clk_in);
      #1 check("pass", xaddr, {4'(i), 12'h000});
    end
    @(posedge sys_clk_in) #1 map_en = 1'b1;
  endtask
  // latched output freezes while hold_n is low, follows when high
  task automatic t_latch();
    @(posedge sys_clk_in) #1 latch_en = 1'b1;
    look(16'h2001, {shadow[2], 4'h1});
    hold_n = 1'b0;
    host.set_addr(16'h9008);
    repeat (6) @(posedge sys_clk_in);
    #1 check("frozen", xaddr, {shadow[2], 4'h1});
    hold_n = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1 check("follow", xaddr, {shadow[9], 4'h8});
    latch_en = 1'b0;
  endtask
  // after the first reset register 12 reads zero through the map
  task automatic t_reset_state();
    look(16'hc00a, {MAP_RESET, 4'ha});
  endtask
  // reset in mid-run clears the output and loaded register 9
  task automatic t_reset_again();
    @(posedge sys_clk_in) #1 rst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 check("reset", xaddr, 16'h0000);
    rst_in = 1'b0;
    for (int i = 0; i < 16; i++) shadow[i] = MAP_RESET;
    look(16'h9008, {shadow[9], 4'h8});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence; reset clears every register to zero
  initial begin
    for (int i = 0; i < 16; i++) shadow[i] = MAP_RESET;
    repeat (2) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    t_reset_state();
    t_map_all();
    t_refuse_reload();
    t_pass();
    t_latch();
    t_reset_again();
    report_and_stop();
  end
  // watchdog: the run needs about 18 us
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb_paged_memory_mapper
